/* hw/amrs_defs.svh */
// constants for the eight-line receive silo
`ifndef AMRS_DEFS_SVH
`define AMRS_DEFS_SVH
// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define AMRS_MCLK_HZ     40000000
`define AMRS_LINES       8
`define AMRS_SILO_DEPTH  64
`define AMRS_ALARM_CNT   16
`define AMRS_OVERSAMPLE  16
`define AMRS_BAUD_SCALE  10
`define AMRS_MID_PHASE   4'h7
`define AMRS_END_PHASE   4'hF
// speeds in tenths of a bit per second
`define AMRS_BAUD0       500
`define AMRS_BAUD1       750
`define AMRS_BAUD2       1100
`define AMRS_BAUD3       1345
`define AMRS_BAUD4       1500
`define AMRS_BAUD5       3000
`define AMRS_BAUD6       6000
`define AMRS_BAUD7       12000
`define AMRS_BAUD8       18000
`define AMRS_BAUD9       20000
`define AMRS_BAUD10      24000
`define AMRS_BAUD11      36000
`define AMRS_BAUD12      48000
`define AMRS_BAUD13      72000
`define AMRS_BAUD14      96000
// ----------------------------------------
// register indices and fields
// ----------------------------------------
`define AMRS_IDX_CSR     1'h0
`define AMRS_IDX_RECEIVE_FIFO_OUTPUT    1'h1
`define AMRS_CSR_CLR     4
`define AMRS_CSR_MSE     5
`define AMRS_CSR_RIE     6
`define AMRS_CSR_RX_CHAR_AVAILABLE   7
`define AMRS_CSR_SAE     12
`define AMRS_CSR_SA      13
`define AMRS_LPR_LINE    2:0
`define AMRS_LPR_CFG     12:3
`define AMRS_CF_LEN      1:0
`define AMRS_CF_STOP2    2
`define AMRS_CF_PAREN    3
`define AMRS_CF_ODD      4
`define AMRS_CF_SPEED    8:5
`define AMRS_CF_RXEN     9
`define AMRS_RB_VALID    15
`define AMRS_RB_OVR      14
`define AMRS_RB_FERR     13
`define AMRS_RB_PERR     12
`define AMRS_RB_LINE     10:8
`define AMRS_RB_DATA     7:0
`endif

/* hw/amrs_pkg.sv */
// types shared by the receive silo design
package amrs_pkg;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4,
    RX_HOLD  = 3'h5,
    RX_BRK   = 3'h6
  } amrs_rx_state_e;
endpackage

/* hw/amrs_rx_line.sv */
// one serial line receiver with its own rate divider
`include "amrs_defs.svh"
module amrs_rx_line (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // control and line format
  input  wire logic        clr,
  input  wire logic        run,
  input  wire logic [1:0]  len,
  input  wire logic        stop2,
  input  wire logic        par_en,
  input  wire logic        par_odd,
  input  wire logic [15:0] div,
  // synchronised serial input
  input  wire logic        rxd,
  // assembled character
  output logic             done,
  output logic [7:0]       data,
  output logic             perr,
  output logic             ferr
);
  amrs_pkg::amrs_rx_state_e st_q, st_d;
  logic [15:0] div_q;
  logic [3:0]  ph_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q;
  logic        par_q;

  wire tick  = run && (div_q == 16'h0000);
  wire mid   = tick && (ph_q == `AMRS_MID_PHASE);
  wire smp   = tick && (ph_q == `AMRS_END_PHASE);
  wire last  = (bit_q == {1'b1, len});
  wire h_end = tick && (ph_q == ((len == 2'h0) ? `AMRS_MID_PHASE : `AMRS_END_PHASE));

  always_comb begin
    st_d = st_q;
    case (st_q)
      amrs_pkg::RX_IDLE:  if (!rxd) st_d = amrs_pkg::RX_START;
      amrs_pkg::RX_START: if (mid) st_d = rxd ? amrs_pkg::RX_IDLE : amrs_pkg::RX_DATA;
      amrs_pkg::RX_DATA:  if (smp && last) st_d = par_en ? amrs_pkg::RX_PAR : amrs_pkg::RX_STOP;
      amrs_pkg::RX_PAR:   if (smp) st_d = amrs_pkg::RX_STOP;
      amrs_pkg::RX_STOP:  if (smp) st_d = !rxd ? amrs_pkg::RX_BRK : (stop2 ? amrs_pkg::RX_HOLD : amrs_pkg::RX_IDLE);
      amrs_pkg::RX_HOLD:  if (h_end) st_d = amrs_pkg::RX_IDLE;
      amrs_pkg::RX_BRK:   if (tick && rxd) st_d = amrs_pkg::RX_IDLE;
      default:            st_d = amrs_pkg::RX_IDLE;
    endcase
    if (!run || clr) st_d = amrs_pkg::RX_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= amrs_pkg::RX_IDLE;
      div_q <= 16'h0000;
      ph_q  <= 4'h0;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      par_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      div_q <= (tick || !run) ? div : div_q - 16'h0001;
      if (st_q == amrs_pkg::RX_IDLE) begin
        ph_q  <= 4'h0;
        bit_q <= 3'h0;
        sh_q  <= 8'h00;
      end else if (tick) begin
        ph_q <= (st_q == amrs_pkg::RX_START && mid) ? 4'h0 : ph_q + 4'h1;
      end
      if (smp && st_q == amrs_pkg::RX_DATA) begin
        sh_q[bit_q] <= rxd;
        bit_q       <= bit_q + 3'h1;
      end
      if (smp && st_q == amrs_pkg::RX_PAR) par_q <= rxd;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else begin
      done <= smp && (st_q == amrs_pkg::RX_STOP);
      if (smp && st_q == amrs_pkg::RX_STOP) begin
        data <= sh_q;
        perr <= par_en && (^sh_q ^ par_q ^ par_odd);
        ferr <= !rxd;
      end
    end
  end

  chk_stop_store: assert property (@(posedge mclk) disable iff (!rst_b)
    done |-> ($past(st_q) == amrs_pkg::RX_STOP) && $past(smp))
    else $error("character stored away from stop centre");
  chk_ferr_waits: assert property (@(posedge mclk) disable iff (!rst_b)
    (done && ferr && !$past(clr)) |-> (st_q == amrs_pkg::RX_BRK))
    else $error("framing error did not hold receiver");
  chk_brk_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (st_q == amrs_pkg::RX_BRK && !rxd && run && !clr) |=> (st_q == amrs_pkg::RX_BRK))
    else $error("receiver resumed while spacing");
endmodule

/* hw/amrs_silo.sv */
// first-in first-out silo ending in the output register
`include "amrs_defs.svh"
module amrs_silo #(
  parameter int DEPTH = `AMRS_SILO_DEPTH,
  parameter int W     = 15
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         clr,
  // fill side
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  output logic              room,
  // drain side
  input  wire logic         pop,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  output logic              more
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;

  // output register counts as one of the slots
  assign room = (cnt_q + (AW+1)'(out_valid)) < (AW+1)'(DEPTH);
  assign more = (cnt_q != '0);
  wire fall = (!out_valid || pop) && more;
  wire put  = push && room;

  always_ff @(posedge mclk) begin
    if (put) mem_q[wp_q] <= push_data;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (clr) begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
    end else begin
      if (put) wp_q <= wp_q + 1'b1;
      if (fall) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(put) - (AW+1)'(fall);
      // next entry one cycle after read
      if (fall) begin
        out_valid <= 1'b1;
        out_data  <= mem_q[rp_q];
      end else if (pop) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

/* hw/amrs_top.sv */
// eight-line asynchronous receiver feeding a shared silo
`include "amrs_defs.svh"
module amrs_top #(
  parameter int DEPTH = `AMRS_SILO_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // register port
  input  wire logic        bus_init,
  input  wire logic        reg_sel,
  input  wire logic        reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // serial lines
  input  wire logic [7:0]  rxd,
  // receiver interrupt request
  output logic             rx_irq
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [15:0] div_of(input logic [3:0] sp);
    int b;
    begin
      case (sp)
        4'h0:    b = `AMRS_BAUD0;
        4'h1:    b = `AMRS_BAUD1;
        4'h2:    b = `AMRS_BAUD2;
        4'h3:    b = `AMRS_BAUD3;
        4'h4:    b = `AMRS_BAUD4;
        4'h5:    b = `AMRS_BAUD5;
        4'h6:    b = `AMRS_BAUD6;
        4'h7:    b = `AMRS_BAUD7;
        4'h8:    b = `AMRS_BAUD8;
        4'h9:    b = `AMRS_BAUD9;
        4'hA:    b = `AMRS_BAUD10;
        4'hB:    b = `AMRS_BAUD11;
        4'hC:    b = `AMRS_BAUD12;
        4'hD:    b = `AMRS_BAUD13;
        default: b = `AMRS_BAUD14;
      endcase
      div_of = 16'((`AMRS_MCLK_HZ * `AMRS_BAUD_SCALE) / (`AMRS_OVERSAMPLE * b) - 1);
    end
  endfunction

  // lowest pending line wins; all lines get served within eight cycles
  function automatic logic [2:0] low_idx(input logic [7:0] m);
    logic [2:0] r;
    begin
      r = 3'h0;
      for (int k = 7; k >= 0; k--) begin
        if (m[k]) begin
          r = 3'(k);
        end
      end
      low_idx = r;
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0]       rxd_m_q, rxd_s_q;
  logic             clr_q, mse_q, rie_q, sae_q, sa_q, irq_q;
  logic [4:0]       acnt_q;
  logic [7:0][9:0]  cfg_q;
  logic [7:0]       pend_q, ovr_q;
  logic [7:0][9:0]  hold_q;
  logic [15:0]      rdata_q, csr_word;
  logic [14:0]      ent;
  logic [7:0]       ln_done, ln_perr, ln_ferr;
  logic [7:0][7:0]  ln_data;
  logic             room, out_valid, more;
  logic [14:0]      out_data;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  wire wr_csr  = reg_sel && reg_wr && (reg_addr == `AMRS_IDX_CSR);
  wire wr_lpr  = reg_sel && reg_wr && (reg_addr == `AMRS_IDX_RECEIVE_FIFO_OUTPUT);
  wire rd_csr  = reg_sel && reg_rd && (reg_addr == `AMRS_IDX_CSR);
  // any buffer read removes the entry
  wire rd_receive_fifo_output = reg_sel && reg_rd && (reg_addr == `AMRS_IDX_RECEIVE_FIFO_OUTPUT);
  wire init    = clr_q || bus_init;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_m_q <= 8'hFF;
      rxd_s_q <= 8'hFF;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // ----------------------------------------
  // control and line parameters
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clr_q <= 1'b0;
      mse_q <= 1'b0;
      rie_q <= 1'b0;
      sae_q <= 1'b0;
    end else begin
      clr_q <= wr_csr && reg_wdata[`AMRS_CSR_CLR];
      if (init) begin
        mse_q <= 1'b0;
        rie_q <= 1'b0;
        sae_q <= 1'b0;
      end else if (wr_csr) begin
        mse_q <= reg_wdata[`AMRS_CSR_MSE];
        rie_q <= reg_wdata[`AMRS_CSR_RIE];
        sae_q <= reg_wdata[`AMRS_CSR_SAE];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
    end else if (init) begin
      cfg_q <= '0;
    end else if (wr_lpr) begin
      cfg_q[reg_wdata[`AMRS_LPR_LINE]] <= reg_wdata[`AMRS_LPR_CFG];
    end
  end

  // ----------------------------------------
  // line receivers
  // ----------------------------------------
  for (genvar i = 0; i < `AMRS_LINES; i++) begin : g_line
    amrs_rx_line u_rx (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .clr     (init),
      .run     (mse_q && cfg_q[i][`AMRS_CF_RXEN]),
      .len     (cfg_q[i][`AMRS_CF_LEN]),
      .stop2   (cfg_q[i][`AMRS_CF_STOP2]),
      .par_en  (cfg_q[i][`AMRS_CF_PAREN]),
      .par_odd (cfg_q[i][`AMRS_CF_ODD]),
      .div     (div_of(cfg_q[i][`AMRS_CF_SPEED])),
      .rxd     (rxd_s_q[i]),
      .done    (ln_done[i]),
      .data    (ln_data[i]),
      .perr    (ln_perr[i]),
      .ferr    (ln_ferr[i])
    );
  end

  // ----------------------------------------
  // silo loading
  // ----------------------------------------
  wire       any  = |pend_q;
  wire [2:0] pick = low_idx(pend_q);
  wire [7:0] sel  = any ? 8'(8'h01 << pick) : 8'h00;
  wire       push = any && room;
  wire       drop = any && !room;

  always_comb begin
    ent = 15'h0000;
    ent[`AMRS_RB_DATA] = hold_q[pick][7:0];
    ent[`AMRS_RB_LINE] = pick;
    ent[`AMRS_RB_PERR] = hold_q[pick][8];
    ent[`AMRS_RB_FERR] = hold_q[pick][9];
    ent[`AMRS_RB_OVR]  = ovr_q[pick];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 8'h00;
      ovr_q  <= 8'h00;
      hold_q <= '0;
    end else if (init) begin
      pend_q <= 8'h00;
      ovr_q  <= 8'h00;
    end else begin
      pend_q <= (pend_q & ~sel) | ln_done;
      ovr_q  <= (ovr_q & ~(push ? sel : 8'h00)) | (drop ? sel : 8'h00) | (ln_done & pend_q & ~sel);
      for (int k = 0; k < `AMRS_LINES; k++) begin
        if (ln_done[k]) begin
          hold_q[k] <= {ln_ferr[k], ln_perr[k], ln_data[k]};
        end
      end
    end
  end

  amrs_silo #(
    .DEPTH (DEPTH),
    .W     (15)
  ) u_silo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .clr       (init),
    .push      (push),
    .push_data (ent),
    .room      (room),
    .pop       (rd_receive_fifo_output),
    .out_valid (out_valid),
    .out_data  (out_data),
    .more      (more)
  );

  // ----------------------------------------
  // alarm and interrupt
  // ----------------------------------------
  wire [4:0] acnt_inc = (acnt_q == 5'(`AMRS_ALARM_CNT)) ? acnt_q : acnt_q + 5'h01;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acnt_q <= 5'h00;
      sa_q   <= 1'b0;
    end else if (init) begin
      acnt_q <= 5'h00;
      sa_q   <= 1'b0;
    end else if (rd_receive_fifo_output) begin
      acnt_q <= push ? 5'h01 : 5'h00;
      sa_q   <= 1'b0;
    end else if (push) begin
      acnt_q <= acnt_inc;
      sa_q   <= sa_q || (acnt_inc == 5'(`AMRS_ALARM_CNT));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rie_q && (sae_q ? sa_q : out_valid);
    end
  end
  assign rx_irq = irq_q;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    csr_word = 16'h0000;
    csr_word[`AMRS_CSR_CLR] = clr_q;
    csr_word[`AMRS_CSR_MSE] = mse_q;
    csr_word[`AMRS_CSR_RIE] = rie_q;
    csr_word[`AMRS_CSR_RX_CHAR_AVAILABLE] = out_valid;
    csr_word[`AMRS_CSR_SAE] = sae_q;
    csr_word[`AMRS_CSR_SA] = sa_q;
  end

  wire [15:0] rb_word = {out_valid, out_data};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (reg_sel && reg_rd) begin
      rdata_q <= rd_csr ? csr_word : rb_word;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_init_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    init |=> (cfg_q == '0) && !out_valid && !mse_q && (pend_q == 8'h00))
    else $error("initialise left state behind");
  chk_scan_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    !mse_q |=> (ln_done == 8'h00))
    else $error("receiver ran without master scan");
  chk_lpr_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_lpr && !init) |=> (cfg_q[$past(reg_wdata[`AMRS_LPR_LINE])] == $past(reg_wdata[`AMRS_LPR_CFG])))
    else $error("line parameter write lost");
  chk_valid_read: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_receive_fifo_output |=> (reg_rdata[`AMRS_RB_VALID] == $past(out_valid)))
    else $error("valid bit mismatch");
  chk_rx_char_available_read: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_csr |=> (reg_rdata[`AMRS_CSR_RX_CHAR_AVAILABLE] == $past(out_valid)))
    else $error("done bit mismatch");
  chk_read_pops: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_receive_fifo_output && out_valid && !more && !init) |=> !out_valid)
    else $error("read did not remove entry");
  chk_next_soon: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_receive_fifo_output && more && !init) |=> out_valid)
    else $error("next entry late");
  chk_irq_off: assert property (@(posedge mclk) disable iff (!rst_b)
    (!rie_q && !sae_q) |=> !rx_irq)
    else $error("interrupt with enables clear");
  chk_irq_done: assert property (@(posedge mclk) disable iff (!rst_b)
    (rie_q && !sae_q && out_valid) |=> rx_irq)
    else $error("done interrupt missing");
  chk_alarm_set: assert property (@(posedge mclk) disable iff (!rst_b)
    (push && !rd_receive_fifo_output && !init && acnt_q == 5'(`AMRS_ALARM_CNT - 1)) |=> sa_q)
    else $error("alarm not raised at sixteen");
  chk_alarm_clr: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_receive_fifo_output && !push) |=> (!sa_q && acnt_q == 5'h00))
    else $error("buffer access did not clear alarm");
  chk_full_ovr: assert property (@(posedge mclk) disable iff (!rst_b)
    (drop && !init) |=> ovr_q[$past(pick)])
    else $error("dropped character not flagged");
  chk_no_loss: assert property (@(posedge mclk) disable iff (!rst_b)
    (ln_done != 8'h00 && !init) |=> ((pend_q & $past(ln_done)) == $past(ln_done)))
    else $error("completed character lost");
endmodule

/* tb/amrs_term_model.sv */
// serial terminal model driving the eight receive lines
module amrs_term_model #(
  parameter int BIT_NS = 104400
) (
  // serial lines, mark is one
  output logic [7:0] rxd
);
  timeunit 1ns;
  timeprecision 100ps;

  // lines rest at mark between frames
  initial rxd = 8'hFF;

  // ----------------------------------------
  // one frame: start, data lsb first, parity, stop
  // ----------------------------------------
  // frame shape per line
  task automatic send(input int ln, input int nbits, input logic [7:0] d,
                      input logic par_on, input logic par_bit, input logic stop_lvl);
    rxd[ln] = 1'b0;
    #BIT_NS;
    for (int i = 0; i < nbits; i++) begin
      rxd[ln] = d[i];
      #BIT_NS;
    end
    if (par_on) begin
      rxd[ln] = par_bit;
      #BIT_NS;
    end
    // a spacing stop here stands for a break
    rxd[ln] = stop_lvl;
    #BIT_NS;
    // back to mark long enough to rearm
    rxd[ln] = 1'b1;
    #BIT_NS;
  endtask
endmodule

/* tb/tb_async_mux_receive_silo.sv */
// self-checking bench for the eight-line receive silo
module tb_async_mux_receive_silo;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk      = 1'b0;
  logic        rst_b     = 1'b0;
  logic        bus_init  = 1'b0;
  logic        reg_sel   = 1'b0;
  logic        reg_addr  = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] got;
  logic [7:0]  rxd;
  logic        rx_irq;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  always #12.5 mclk = ~mclk;

  amrs_top dut (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .bus_init  (bus_init),
    .reg_sel   (reg_sel),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .rxd       (rxd),
    .rx_irq    (rx_irq)
  );

  // 16x tick of 261 clocks, one more than the 260-clock tick at the fastest speed code
  amrs_term_model #(.BIT_NS(16 * 261 * 25)) term (
    .rxd (rxd)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one-cycle strobe; read data lands the cycle after
  task automatic acc(input logic wr, input logic a, input logic [15:0] wd);
    @(negedge mclk);
    reg_sel   = 1'b1;
    reg_wr    = wr;
    reg_rd    = ~wr;
    reg_addr  = a;
    reg_wdata = wd;
    @(negedge mclk);
    reg_sel = 1'b0;
    reg_wr  = 1'b0;
    reg_rd  = 1'b0;
    got     = reg_rdata;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // frames take about 84k clocks in all
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    acc(1'b0, 1'b0, 16'h0000);
    chk16(got, 16'h0000);
    acc(1'b0, 1'b1, 16'h0000);
    chk1(got[15], 1'b0);
    chk1(rx_irq, 1'b0);
  endtask

  // lines three and six finish together, lower line first; line two later
  task automatic t_frames();
    acc(1'b1, 1'b1, 16'h1E43);
    acc(1'b1, 1'b1, 16'h1E46);
    acc(1'b1, 1'b1, 16'h1EFA);
    acc(1'b1, 1'b0, 16'h0060);
    fork
      term.send(3, 5, 8'h15, 1'b1, ~(^8'h15), 1'b1);
      term.send(6, 5, 8'h0A, 1'b1, ^8'h0A, 1'b0);
      term.send(2, 8, 8'hA5, 1'b1, ~(^8'hA5), 1'b1);
    join
    acc(1'b0, 1'b0, 16'h0000);
    chk1(got[7], 1'b1);
    chk1(got[13], 1'b0);
    chk1(rx_irq, 1'b1);
    acc(1'b1, 1'b0, 16'h0020);
    repeat (3) @(negedge mclk);
    chk1(rx_irq, 1'b0);
    acc(1'b1, 1'b0, 16'h0060);
    repeat (3) @(negedge mclk);
    chk1(rx_irq, 1'b1);
    // host keeps reads a microsecond apart
    acc(1'b0, 1'b1, 16'h0000);
    chk16(got, 16'h9315);
    repeat (40) @(negedge mclk);
    acc(1'b0, 1'b1, 16'h0000);
    chk16(got, 16'hA60A);
    repeat (40) @(negedge mclk);
    acc(1'b0, 1'b1, 16'h0000);
    chk16(got, 16'h82A5);
    repeat (40) @(negedge mclk);
    acc(1'b0, 1'b1, 16'h0000);
    chk1(got[15], 1'b0);
    acc(1'b0, 1'b0, 16'h0000);
    chk1(got[7], 1'b0);
    chk1(rx_irq, 1'b0);
  endtask

  // both initialise paths; line six stays cleared, line seven is set up again
  task automatic t_init();
    @(negedge mclk);
    bus_init = 1'b1;
    @(negedge mclk);
    bus_init = 1'b0;
    acc(1'b0, 1'b0, 16'h0000);
    chk16(got, 16'h0000);
    acc(1'b0, 1'b1, 16'h0000);
    chk1(got[15], 1'b0);
    acc(1'b1, 1'b0, 16'h0020);
    acc(1'b1, 1'b0, 16'h0010);
    repeat (2) @(negedge mclk);
    acc(1'b0, 1'b0, 16'h0000);
    chk16(got, 16'h0000);
    acc(1'b1, 1'b1, 16'h1E07);
    acc(1'b1, 1'b0, 16'h0020);
    fork
      term.send(6, 5, 8'h15, 1'b0, 1'b0, 1'b1);
      term.send(7, 5, 8'h15, 1'b0, 1'b0, 1'b1);
    join
    acc(1'b0, 1'b0, 16'h0000);
    chk16(got, 16'h00A0);
    @(negedge mclk);
    bus_init = 1'b1;
    @(negedge mclk);
    bus_init = 1'b0;
    // a live line six would sit in the output ahead of line seven
    acc(1'b0, 1'b1, 16'h0000);
    chk16(got, 16'h0715);
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_frames();
    t_init();
    close_out();
  end
endmodule
